// File: rtl/supply_monitor_defs.svh
// offsets, field positions, reset values and timing constants of the supply monitor
`ifndef SUPPLY_MONITOR_DEFS_SVH
`define SUPPLY_MONITOR_DEFS_SVH
`define SM_ADDR_W            4
`define SM_OFF_CONTROL       4'h0
`define SM_OFF_IRQ_STATUS    4'h4
`define SM_OFF_IRQ_MASK      4'h8
`define SM_BIT_DIG_OK        7
`define SM_BIT_ANA_OK        6
`define SM_BIT_FLAG          5
`define SM_BIT_DSEL_HI       4
`define SM_BIT_DSEL_LO       3
`define SM_BIT_ASEL_HI       2
`define SM_BIT_ASEL_LO       1
`define SM_BIT_ENABLE        0
`define SM_CTRL_RESET        8'h00
`define SM_MASK_RESET        8'h00
`define SM_QUAL_TIME_MS      250
`define SM_CLK_HZ            40000000
`define SM_QUAL_CYCLES       ((`SM_CLK_HZ / 1000) * `SM_QUAL_TIME_MS)
`define SM_GLITCH_CYCLES     4
`define SM_IRQ_SET           0
`define SM_IRQ_CLEAR         1
`define SM_IRQ_COUNT         2
`endif

// File: rtl/supply_monitor_pkg.sv
// types shared by the supply monitor design
package supply_monitor_pkg;
    typedef struct packed {
        logic [1:0] digital_threshold_sel;
        logic [1:0] analog_threshold_sel;
        logic       monitor_enable;
    } monitor_cfg_s;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_LOW   = 3'b010,
        ST_QUAL  = 3'b100
    } monitor_state_e;
endpackage

// File: rtl/supply_monitor_control.sv
// supply monitor control and status logic with a classic wishbone slave
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.svh"

// register map, byte offsets, data on the low lane
//   0x0 control:
//     7    digital rail ok, live, read only
//     6    analog rail ok, live, read only
//     5    low-supply flag, sticky
//     4:3  digital trip point select
//     2:1  analog trip point select
//     0    monitor enable
//   0x4 interrupt status, cleared by reading it:
//     0    flag rose
//     1    flag cleared after qualification
//   0x8 interrupt mask, same layout as status
//   other offsets read zero, writes dropped, still acked
//
// trip point codes for both select fields
//   00   4.63 v
//   01   3.08 v
//   10   2.93 v
//   11   2.63 v
//
// bus timing
//   request taken on an edge with cyc and stb high and ack low
//   ack and read data stand for the single following cycle
//   a write lands on the taking edge
//   ack drops even if the master keeps stb high
//
// flag timing
//   set after GLITCH_CYCLES consecutive low samples while enabled
//   shorter dips restart the filter and leave the flag alone
//   cleared after QUAL_CYCLES consecutive cycles with both rails high
//   any low sample during qualification restarts it
//   software may set the flag at any time
//   software clear lands only while both rails are high
//   a set in the same cycle beats any clear
//   disabling stops filter and qualification but keeps the flag
//
// flag state machine
//   idle: a qualified low moves to low
//   idle with the flag still set and both rails high moves to qual
//   low: waits for both rails high, then qual
//   qual: counts high cycles; any low goes back to low
//   qual: expiry clears the flag and returns to idle
//   disable from low or qual returns to idle
//
// interrupt output
//   high while a status bit and its mask bit are both set
//   reading status drops a bit unless a new event lands that cycle
//
// parameters
//   QUAL_CYCLES   clock cycles in the 250 ms qualification
//   GLITCH_CYCLES consecutive low samples before a dip counts
//   both may be shortened in simulation to keep runs brief
//
// limitations
//   comparator inputs are taken as already synchronous;
//   a free-running comparator needs a synchroniser outside
//   a flag set by software alone still waits a full qualification
//   all registers are synchronous to clk_i and cleared by rst_i, except the state, which loads ST_IDLE (3'b001)
//

module supply_monitor_control
    import supply_monitor_pkg::*;
#(
    parameter int unsigned QUAL_CYCLES   = `SM_QUAL_CYCLES,
    parameter int unsigned GLITCH_CYCLES = `SM_GLITCH_CYCLES
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [`SM_ADDR_W-1:0]  adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    input  wire logic                   digital_rail_ok_i,
    input  wire logic                   analog_rail_ok_i,
    output logic      [1:0]             digital_threshold_sel_o,
    output logic      [1:0]             analog_threshold_sel_o,
    output logic                        monitor_enable_o,
    output logic                        low_supply_flag_o,
    output logic                        irq_o
);

    localparam int GW = $clog2(GLITCH_CYCLES + 1);
    localparam int QW = $clog2(QUAL_CYCLES + 1);

    monitor_cfg_s   cfg_q;

    monitor_state_e state_q;
    monitor_state_e state_d;

    logic           flag_q;
    logic           flag_d;

    logic [GW-1:0]  glitch_cnt_q;
    logic [GW-1:0]  glitch_cnt_d;

    logic [QW-1:0]  qual_cnt_q;
    logic [QW-1:0]  qual_cnt_d;

    logic [1:0]     irq_status_q;
    logic [1:0]     irq_mask_q;

    logic           ack_q;
    logic [31:0]    dat_q;
    logic [31:0]    rd_data;

    function automatic logic hit(input logic [`SM_ADDR_W-1:0] a,
                                 input logic [`SM_ADDR_W-1:0] off);
        return a == off;
    endfunction

    // bus decode
    wire req        = cyc_i & stb_i & ~ack_q;
    wire wr_lane0   = req & we_i & sel_i[0];
    wire hit_ctrl   = hit(adr_i, `SM_OFF_CONTROL);
    wire hit_stat   = hit(adr_i, `SM_OFF_IRQ_STATUS);
    wire hit_mask   = hit(adr_i, `SM_OFF_IRQ_MASK);
    wire wr_ctrl    = wr_lane0 & hit_ctrl;
    wire wr_mask    = wr_lane0 & hit_mask;
    wire rd_stat    = req & ~we_i & hit_stat;

    wire both_ok    = digital_rail_ok_i & analog_rail_ok_i;
    wire any_low    = ~both_ok;
    wire enabled    = cfg_q.monitor_enable;

    // a dip must persist this long before it counts as a real low supply
    wire low_qualified = (glitch_cnt_q == GW'(GLITCH_CYCLES));
    wire qual_done     = (qual_cnt_q == QW'(QUAL_CYCLES - 1));

    wire sw_flag_val   = dat_i[`SM_BIT_FLAG];
    wire sw_set        = wr_ctrl & sw_flag_val;
    wire sw_clear_ok   = wr_ctrl & ~sw_flag_val & both_ok;

    always_comb begin
        glitch_cnt_d = '0;
        if (enabled && any_low) begin
            if (low_qualified) begin
                glitch_cnt_d = glitch_cnt_q;
            end else begin
                glitch_cnt_d = glitch_cnt_q + GW'(1);
            end
        end
    end

    // flag state machine: idle, low seen, qualifying recovery
    always_comb begin
        state_d    = state_q;
        qual_cnt_d = '0;
        unique case (state_q)
            ST_IDLE: begin
                if (enabled && low_qualified) begin
                    state_d = ST_LOW;
                end else if (enabled && flag_q && both_ok) begin
                    state_d = ST_QUAL;
                end
            end
            ST_LOW: begin
                if (!enabled) begin
                    state_d = ST_IDLE;
                end else if (both_ok) begin
                    state_d = ST_QUAL;
                end
            end
            ST_QUAL: begin
                if (!enabled) begin
                    state_d = ST_IDLE;
                end else if (any_low) begin
                    state_d = ST_LOW;
                end else if (qual_done) begin
                    state_d = ST_IDLE;
                end else begin
                    qual_cnt_d = qual_cnt_q + QW'(1);
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    wire hw_set   = enabled & low_qualified;
    wire hw_clear = (state_q == ST_QUAL) & enabled & both_ok & qual_done;

    // set wins over any clear in the same cycle
    always_comb begin
        flag_d = flag_q;
        if (hw_clear || sw_clear_ok) begin
            flag_d = 1'b0;
        end
        if (hw_set || sw_set) begin
            flag_d = 1'b1;
        end
    end

    // status bit 0: flag rose; bit 1: flag cleared by qualification
    wire flag_rise = flag_d & ~flag_q;
    wire [1:0] irq_evt;
    assign irq_evt[`SM_IRQ_SET]   = flag_rise;
    assign irq_evt[`SM_IRQ_CLEAR] = hw_clear & flag_q;

    wire [7:0] ctrl_view = {digital_rail_ok_i,
                            analog_rail_ok_i,
                            flag_q,
                            cfg_q.digital_threshold_sel,
                            cfg_q.analog_threshold_sel,
                            cfg_q.monitor_enable};

    wire [7:0] stat_view = {6'h00, irq_status_q};

    wire [7:0] mask_view = {6'h00, irq_mask_q};

    // unmapped offsets read as zero and are still acknowledged
    always_comb begin
        rd_data = 32'h00000000;
        if (hit_ctrl) begin
            rd_data = {24'h000000, ctrl_view};
        end
        if (hit_stat) begin
            rd_data = {24'h000000, stat_view};
        end
        if (hit_mask) begin
            rd_data = {24'h000000, mask_view};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= monitor_cfg_s'(`SM_CTRL_RESET);
        end else if (wr_ctrl) begin
            cfg_q.digital_threshold_sel <= dat_i[`SM_BIT_DSEL_HI:`SM_BIT_DSEL_LO];
            cfg_q.analog_threshold_sel  <= dat_i[`SM_BIT_ASEL_HI:`SM_BIT_ASEL_LO];
            cfg_q.monitor_enable        <= dat_i[`SM_BIT_ENABLE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            glitch_cnt_q <= '0;
        end else begin
            glitch_cnt_q <= glitch_cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qual_cnt_q <= '0;
        end else begin
            qual_cnt_q <= qual_cnt_d;
        end
    end

    // per-bit sticky status: an event in the cycle of the clearing read wins
    for (genvar gi = 0; gi < `SM_IRQ_COUNT; gi++) begin : g_irq_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                irq_status_q[gi] <= 1'b0;
            end else if (irq_evt[gi]) begin
                irq_status_q[gi] <= 1'b1;
            end else if (rd_stat) begin
                irq_status_q[gi] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= 2'(`SM_MASK_RESET);
        end else if (wr_mask) begin
            irq_mask_q <= dat_i[`SM_IRQ_COUNT-1:0];
        end
    end

    // one wait state: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // read data is zero outside the acknowledge cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
        end else if (req && !we_i) begin
            dat_q <= rd_data;
        end else begin
            dat_q <= 32'h00000000;
        end
    end

    // bus side
    assign ack_o                   = ack_q;
    assign dat_o                   = dat_q;

    // configuration toward the comparators
    assign digital_threshold_sel_o = cfg_q.digital_threshold_sel;
    assign analog_threshold_sel_o  = cfg_q.analog_threshold_sel;
    assign monitor_enable_o        = cfg_q.monitor_enable;

    // flag and interrupt
    assign low_supply_flag_o       = flag_q;
    assign irq_o                   = |(irq_status_q & irq_mask_q);

endmodule // supply_monitor_control
`default_nettype wire

// File: tb/supply_monitor_control_assertions.sv
// port-level assertions of the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_checker #(parameter int unsigned QUAL_CYCLES = 20) (
    input wire logic        clk_i, rst_i, we_i, ack_o, digital_rail_ok_i, analog_rail_ok_i,
    input wire logic        monitor_enable_o, low_supply_flag_o,
    input wire logic [3:0]  adr_i, sel_i,
    input wire logic [1:0]  digital_threshold_sel_o, analog_threshold_sel_o,
    input wire logic [31:0] dat_i, dat_o
);
    wire         both_hi = digital_rail_ok_i && analog_rail_ok_i;
    wire         low_run = monitor_enable_o && !both_hi;
    logic        we_q;
    logic [31:0] hi_cnt_q;
    wire         sw_wr = ack_o && we_q;
    // count restarts on writes, since a write may have set the flag itself
    always_ff @(posedge clk_i) begin
        we_q     <= we_i;
        hi_cnt_q <= (rst_i || sw_wr || !both_hi || !monitor_enable_o) ? 32'h0 : hi_cnt_q + 32'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd; ack_o && !we_q && $past(adr_i) == 4'h0; endsequence
    sequence s_wr; sw_wr && $past(adr_i) == 4'h0 && $past(sel_i[0]); endsequence
    a_dig_live: assert property (s_rd |-> dat_o[7] == $past(digital_rail_ok_i))
        else $error("digital ok bit wrong");
    a_ana_live: assert property (s_rd |-> dat_o[6] == $past(analog_rail_ok_i))
        else $error("analog ok bit wrong");
    a_flag_sets: assert property (low_run [*6] |-> low_supply_flag_o)
        else $error("flag not set");
    a_glitch_gone: assert property ($rose(low_supply_flag_o) && !sw_wr |->
        $past(low_run) && $past(low_run, 2)) else $error("flag set without low run");
    a_qual_clears: assert property (hi_cnt_q > QUAL_CYCLES + 2 |-> !low_supply_flag_o)
        else $error("flag not cleared");
    a_no_early_clear: assert property ($fell(low_supply_flag_o) && !sw_wr |->
        hi_cnt_q >= QUAL_CYCLES - 2) else $error("flag cleared early");
    a_clear_refused: assert property (s_wr ##0 !$past(dat_i[5]) && !$past(both_hi) &&
        $past(low_supply_flag_o) |-> low_supply_flag_o) else $error("flag cleared while low");
    a_write_fields: assert property (s_wr |->
        {digital_threshold_sel_o, analog_threshold_sel_o, monitor_enable_o} == $past(dat_i[4:0]))
        else $error("control fields wrong");
endmodule // supply_monitor_checker
`default_nettype wire

// File: tb/rail_comparator_model.sv
// behavioural model of the two rail comparators
`timescale 1ns/1ps
`default_nettype none
module rail_comparator_model (
    input  wire logic        clk_i,
    input  wire logic [12:0] dig_mv_i,
    input  wire logic [12:0] ana_mv_i,
    input  wire logic [1:0]  dig_sel_i,
    input  wire logic [1:0]  ana_sel_i,
    output var  logic        dig_ok_o,
    output var  logic        ana_ok_o
);
    logic [12:0] trip_mv [4] = '{13'h1216, 13'h0C08, 13'h0B72, 13'h0A46};
    initial {dig_ok_o, ana_ok_o} = 2'b11;
    // one clock of settling, so a dip shorter than the filter still reaches the block
    always @(posedge clk_i) begin
        dig_ok_o <= dig_mv_i > trip_mv[dig_sel_i];
        ana_ok_o <= ana_mv_i > trip_mv[ana_sel_i];
    end
endmodule // rail_comparator_model
`default_nettype wire

// File: tb/supply_monitor_control_test.sv
// self-checking bench of the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_control_test;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rnd = 32'h00005CE1;
    logic [12:0] dmv = 13'h1388, amv = 13'h1388;
    logic [12:0] trip [4] = '{13'h1216, 13'h0C08, 13'h0B72, 13'h0A46};
    logic [1:0]  digital_threshold_sel_o, analog_threshold_sel_o;
    logic [15:0] e, exp_q [$];
    logic [7:0]  x;
    logic        ack_o, digital_rail_ok_i, analog_rail_ok_i;
    logic        monitor_enable_o, low_supply_flag_o, irq_o;
    int          n_errors = 0, n_tests = 0, cycles = 0;
    supply_monitor_control #(.QUAL_CYCLES(20), .GLITCH_CYCLES(4)) u_dut (.clk_i, .rst_i, .cyc_i,
        .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .digital_rail_ok_i,
        .analog_rail_ok_i, .digital_threshold_sel_o, .analog_threshold_sel_o, .monitor_enable_o,
        .low_supply_flag_o, .irq_o);
    rail_comparator_model u_rails (.clk_i, .dig_mv_i(dmv), .ana_mv_i(amv),
        .dig_sel_i(digital_threshold_sel_o), .ana_sel_i(analog_threshold_sel_o),
        .dig_ok_o(digital_rail_ok_i), .ana_ok_o(analog_rail_ok_i));
    initial forever #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
        n_tests++;
        if ((got & msk) !== (exp & msk)) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n == 20) n_errors++;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] ex, input logic [7:0] m);
        exp_q.push_back({m, ex});
        wb(1'b0, a, 8'h00);
    endtask
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // read data is judged against the oldest note at the acknowledging edge
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            close_out();
        end else if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(dat_o[7:0], e[7:0], e[15:8]);
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(4'h0, 8'hC0, 8'hFF);
        rd(4'h8, 8'h00, 8'hFF);
        wb(1'b1, 4'hC, 8'hFF);
        rd(4'hC, 8'h00, 8'hFF);
        wb(1'b1, 4'h8, 8'h03);
        $display("reset done");
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            dmv <= 13'h09C4 + {1'b0, rnd[11:0]};
            amv <= 13'h09C4 + {1'b0, rnd[27:16]};
            wb(1'b1, 4'h0, {3'b000, i[1:0], ~i[1:0], 1'b1});
            x = {dmv > trip[i[1:0]], amv > trip[~i[1:0]], 1'b0, i[1:0], ~i[1:0], 1'b1};
            rd(4'h0, x, 8'hDF);
        end
        $display("fields done");
        {dmv, amv} <= {13'h1388, 13'h1388};
        // let any flag left by the random rails qualify and clear first
        repeat (40) @(posedge clk_i);
        wb(1'b1, 4'h0, 8'h01);
        wb(1'b0, 4'h4, 8'h00);
        dmv <= 13'h0800;
        repeat (2) @(posedge clk_i);
        dmv <= 13'h1388;
        repeat (8) @(posedge clk_i);
        rd(4'h0, 8'hC1, 8'hFF);
        chk({7'h0, irq_o}, 8'h00, 8'hFF);
        dmv <= 13'h0800;
        repeat (10) @(posedge clk_i);
        chk({7'h0, irq_o}, 8'h01, 8'hFF);
        wb(1'b1, 4'h0, 8'h01);
        rd(4'h0, 8'h61, 8'hFF);
        rd(4'h4, 8'h01, 8'h03);
        chk({7'h0, irq_o}, 8'h00, 8'hFF);
        dmv <= 13'h1388;
        repeat (8) @(posedge clk_i);
        rd(4'h0, 8'hE1, 8'hFF);
        repeat (30) @(posedge clk_i);
        rd(4'h0, 8'hC1, 8'hFF);
        rd(4'h4, 8'h02, 8'h03);
        $display("flag done");
        wb(1'b1, 4'h0, 8'h00);
        dmv <= 13'h0800;
        repeat (10) @(posedge clk_i);
        rd(4'h0, 8'h40, 8'hFF);
        $display("disable done");
        close_out();
    end
endmodule // supply_monitor_control_test
bind supply_monitor_control supply_monitor_checker #(.QUAL_CYCLES(QUAL_CYCLES)) u_chk (.clk_i,
    .rst_i, .we_i, .ack_o, .digital_rail_ok_i, .analog_rail_ok_i, .monitor_enable_o,
    .low_supply_flag_o, .adr_i, .sel_i, .digital_threshold_sel_o, .analog_threshold_sel_o,
    .dat_i, .dat_o);
`default_nettype wire
